// ---- pmi_device.sv ----
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - Errors recorded; interrupt only while enable set.
// - No error sources: status/control read zero.
// - Separate secure and non-secure error registers.
// - Level form: interrupt while code non-zero.
// - Level form: software non-zero code write raises interrupt.
// - Handler clears by writing zero code.
// - Edge form: one pulse per hardware error.
// - Edge form: software writes never pulse.
// - Enabled monitor overflow raises overflow interrupt.
// - Monitor control kept per security space.
// - Each space enable gates its own interrupt.
// - Overflow interrupt is level while pending.
// - Deasserts only after all enabled flags cleared.
// - Level form recommended, chosen by default.
// - Two error outputs, secure and non-secure.
// - Two overflow outputs, secure and non-secure.
// - Requesters keep partition_id in range.
// - Requesters keep perf_monitor_group in range.
// - Every request carries a partition_id.
// - Same id and space share settings.
// - Space zero uses secure table.
module pmi_device import pmi_pkg::*; #(
	parameter bit LEVEL_FORM = 1'b1,
	parameter bit HAS_ERRORS = 1'b1
) (
	// Clock and reset.
	input  wire logic                  clk_in,
	input  wire logic                  rst_b_in,
	// Link to requesters and interrupt controller.
	pmi_link_if.device                 link,
	// Register port.
	input  wire logic [PMI_ADDR_W-1:0] addr_in,
	input  wire logic [PMI_DATA_W-1:0] wdata_in,
	input  wire logic                  wr_in,
	input  wire logic                  rd_in,
	output logic      [PMI_DATA_W-1:0] rdata_out,
	// Hardware event inputs, per space (bit 0 secure, bit 1 non-secure).
	input  wire logic [1:0]            err_det_in,
	input  wire logic [PMI_CODE_W-1:0] err_code_in,
	input  wire logic [PMI_MON_N-1:0]  oflow_s_in,
	input  wire logic [PMI_MON_N-1:0]  oflow_ns_in,
	// Selected settings for the current request.
	output logic      [PMI_SET_W-1:0]  req_setting_out,
	output logic                       req_valid_out
);
	// All state lives in one packed struct, filled by one combinational process and registered by one.
	typedef struct packed {
		logic [1:0][PMI_CODE_W-1:0]         code;
		logic [1:0]                         irq_en;
		logic [1:0][PMI_MON_N-1:0]          mon_en;
		logic [1:0][PMI_MON_N-1:0]          mon_st;
		logic [1:0]                         err_irq;
		logic [1:0]                         of_irq;
		logic [PMI_DATA_W-1:0]              rdata;
		logic [1:0][PMI_PARTS-1:0][PMI_SET_W-1:0] table_set;
		logic [PMI_SET_W-1:0]               setting;
		logic                               req_valid;
	} pmi_dev_state_t;

	pmi_dev_state_t state_reg;
	pmi_dev_state_t state_next;

	// Partition index width; ids above the table size alias onto its low entries.
	localparam int IDX_W = $clog2(PMI_PARTS);

	// Write strobes, one bit per security space.
	logic [1:0]                 code_wr;
	logic [1:0]                 en_wr;
	logic [1:0]                 mon_wr;
	// Read strobes, one bit per security space.
	logic [1:0]                 code_rd;
	logic [1:0]                 en_rd;
	logic [1:0]                 mon_rd;

	// Read words, one per space, already placed in their fields.
	logic [1:0][PMI_DATA_W-1:0] code_word;
	logic [1:0][PMI_DATA_W-1:0] en_word;
	logic [1:0][PMI_DATA_W-1:0] mon_word;

	// Overflow pulses gathered by space.
	logic [1:0][PMI_MON_N-1:0]  oflow;

	// Settings table write port and request lookup index.
	logic                       tbl_wr;
	logic                       tbl_space;
	logic [IDX_W-1:0]           tbl_idx;
	logic [PMI_SET_W-1:0]       tbl_val;
	logic [IDX_W-1:0]           req_idx;

	// Secure copies are index 0 and non-secure index 1, matching the request space bit.
	assign oflow = {oflow_ns_in, oflow_s_in};

	// One decoder per security space, so neither space can reach the other's copies.
	for (genvar s = 0; s < 2; s++) begin : g_space
		// Offsets of this space's three registers.
		localparam logic [PMI_ADDR_W-1:0] CODE_OFS = (s == 0) ? PMI_OFS_ESR_S : PMI_OFS_ESR_NS;
		localparam logic [PMI_ADDR_W-1:0] EN_OFS   = (s == 0) ? PMI_OFS_ECR_S : PMI_OFS_ECR_NS;
		localparam logic [PMI_ADDR_W-1:0] MON_OFS  = (s == 0) ? PMI_OFS_MON_S : PMI_OFS_MON_NS;

		// Error registers decode to nothing without error sources, so they read zero and drop writes.
		assign code_wr[s] = wr_in && HAS_ERRORS && (addr_in == CODE_OFS);
		assign en_wr[s]   = wr_in && HAS_ERRORS && (addr_in == EN_OFS);
		assign code_rd[s] = rd_in && HAS_ERRORS && (addr_in == CODE_OFS);
		assign en_rd[s]   = rd_in && HAS_ERRORS && (addr_in == EN_OFS);

		// Monitor control exists in both spaces whatever the error support.
		assign mon_wr[s] = wr_in && (addr_in == MON_OFS);
		assign mon_rd[s] = rd_in && (addr_in == MON_OFS);

		// Error read words, zero-filled around the implemented fields.
		assign code_word[s] = {{(PMI_DATA_W-PMI_CODE_W){1'b0}}, state_reg.code[s]};
		assign en_word[s]   = {{(PMI_DATA_W-1){1'b0}}, state_reg.irq_en[s]};

		// Monitor read word carries the enables low and the sticky flags above them.
		assign mon_word[s] = {{(PMI_DATA_W-PMI_MON_ST_LSB-PMI_MON_N){1'b0}}, state_reg.mon_st[s],
			{(PMI_MON_ST_LSB-PMI_MON_N){1'b0}}, state_reg.mon_en[s]};
	end : g_space

	// Settings table port: one write word carries space, index and value together.
	assign tbl_wr    = wr_in && (addr_in == PMI_OFS_SET);
	assign tbl_space = wdata_in[PMI_SET_SPACE];
	assign tbl_idx   = wdata_in[PMI_SET_PART +: IDX_W];
	assign tbl_val   = wdata_in[PMI_SET_W-1:0];
	// Only the low id bits index the table, so an out-of-range id lands on a shared entry.
	assign req_idx   = link.partition_id[IDX_W-1:0];

	// Next state, computed space by space.
	always_comb begin
		state_next = state_reg;
		// Read data falls back to zero when no read is decoded.
		state_next.rdata = PMI_ZERO_WORD;
		for (int s = 0; s < 2; s++) begin
			// Software writes; a write never yields an edge-form pulse.
			if (code_wr[s]) begin
				state_next.code[s] = wdata_in[PMI_CODE_W-1:0];
			end
			if (en_wr[s]) begin
				state_next.irq_en[s] = wdata_in[PMI_ECR_EN_BIT];
			end
			if (mon_wr[s]) begin
				state_next.mon_en[s] = wdata_in[PMI_MON_EN_LSB +: PMI_MON_N];
				// Writing zero clears a flag; a one leaves it alone.
				state_next.mon_st[s] = state_reg.mon_st[s] & wdata_in[PMI_MON_ST_LSB +: PMI_MON_N];
			end

			// Hardware events win over a same-cycle clear, so no overflow is ever lost.
			state_next.mon_st[s] = state_next.mon_st[s] | oflow[s];
			// A detected error overrides a same-cycle software write of the code.
			if (err_det_in[s] && HAS_ERRORS) begin
				state_next.code[s] = err_code_in;
			end

			// Error output, gated by its own space enable.
			if (LEVEL_FORM) begin
				state_next.err_irq[s] = state_next.irq_en[s] && (state_next.code[s] != PMI_CODE_NONE);
			end else begin
				// Only a detection pulses; the code register itself is not watched for changes.
				state_next.err_irq[s] = state_reg.irq_en[s] && err_det_in[s] && HAS_ERRORS;
			end

			// Overflow level holds while any enabled flag stays set.
			state_next.of_irq[s] = |(state_next.mon_st[s] & state_next.mon_en[s]);

			// Reads return the value held before any same-cycle write.
			if (code_rd[s]) begin
				state_next.rdata = code_word[s];
			end
			if (en_rd[s]) begin
				state_next.rdata = en_word[s];
			end
			if (mon_rd[s]) begin
				state_next.rdata = mon_word[s];
			end
		end

		// Settings table write, into the table of the space named in the word.
		if (tbl_wr) begin
			state_next.table_set[tbl_space][tbl_idx] = tbl_val;
		end

		// One shared entry per id and space; the space bit picks the table.
		state_next.req_valid = link.req_valid;
		if (link.req_valid) begin
			state_next.setting = state_reg.table_set[link.secure_space_select][req_idx];
		end
	end

	// State register.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			// Every flag clears, so no interrupt is pending when reset is released.
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Interrupt lines leave straight from flip-flops, so the controller never sees a glitch.
	assign link.error_irq    = state_reg.err_irq;
	assign link.overflow_irq = state_reg.of_irq;

	// Read data stands for the one cycle after the read strobe and is zero otherwise.
	assign rdata_out         = state_reg.rdata;

	// Lookup result and its strobe, one cycle after the request on the link.
	assign req_setting_out   = state_reg.setting;
	assign req_valid_out     = state_reg.req_valid;
endmodule : pmi_device

// ---- pmi_pkg.sv ----
package pmi_pkg;
	// Widths of the request identifiers, code, address, data and settings; the monitor count and the table size.
	localparam int PMI_PART_W   = 8;
	localparam int PMI_GROUP_W  = 4;
	localparam int PMI_MON_N    = 4;
	localparam int PMI_CODE_W   = 4;
	localparam int PMI_ADDR_W   = 4;
	localparam int PMI_DATA_W   = 32;
	localparam int PMI_PARTS    = 16;
	localparam int PMI_SET_W    = 16;

	// Register offsets, one per security space except the shared settings table port.
	localparam logic [PMI_ADDR_W-1:0] PMI_OFS_ESR_S  = 4'h0;
	localparam logic [PMI_ADDR_W-1:0] PMI_OFS_ECR_S  = 4'h1;
	localparam logic [PMI_ADDR_W-1:0] PMI_OFS_MON_S  = 4'h2;
	localparam logic [PMI_ADDR_W-1:0] PMI_OFS_ESR_NS = 4'h4;
	localparam logic [PMI_ADDR_W-1:0] PMI_OFS_ECR_NS = 4'h5;
	localparam logic [PMI_ADDR_W-1:0] PMI_OFS_MON_NS = 4'h6;
	localparam logic [PMI_ADDR_W-1:0] PMI_OFS_SET    = 4'h8;

	// Field positions.
	localparam int PMI_ECR_EN_BIT  = 0;
	localparam int PMI_MON_EN_LSB  = 0;
	localparam int PMI_MON_ST_LSB  = 8;
	localparam int PMI_SET_SPACE   = 16;
	localparam int PMI_SET_PART    = 24;

	// Space encoding on requests: zero selects the secure table.
	localparam logic PMI_SPACE_SEC = 1'b0;
	localparam logic PMI_SPACE_NS  = 1'b1;
	localparam logic [PMI_CODE_W-1:0] PMI_CODE_NONE = 4'h0;
	localparam logic [PMI_DATA_W-1:0] PMI_ZERO_WORD = 32'h0000_0000;
endpackage : pmi_pkg

// ---- pmi_link_if.sv ----
`timescale 1ns/1ps
interface pmi_link_if;
	import pmi_pkg::*;
	// Request side.
	logic                   req_valid;
	logic [PMI_PART_W-1:0]  partition_id;
	logic [PMI_GROUP_W-1:0] perf_monitor_group;
	logic                   secure_space_select;
	// Interrupt side.
	logic [1:0]             error_irq;
	logic [1:0]             overflow_irq;

	modport device (input req_valid, partition_id, perf_monitor_group, secure_space_select,
		output error_irq, overflow_irq);
	modport host (output req_valid, partition_id, perf_monitor_group, secure_space_select,
		input error_irq, overflow_irq);
endinterface : pmi_link_if

// ---- pmi_host.sv ----
`timescale 1ns/1ps
module pmi_host import pmi_pkg::*; (
	// Clock and reset.
	input  wire logic                   clk_in,
	input  wire logic                   rst_b_in,
	// Link side.
	pmi_link_if.host                    link,
	// User request side.
	input  wire logic                   req_in,
	input  wire logic [PMI_PART_W-1:0]  part_in,
	input  wire logic [PMI_GROUP_W-1:0] group_in,
	input  wire logic                   space_in,
	input  wire logic [PMI_PART_W-1:0]  part_max_in,
	input  wire logic [PMI_GROUP_W-1:0] group_max_in,
	// Interrupt levels seen by the controller.
	output logic      [1:0]             err_irq_out,
	output logic      [1:0]             of_irq_out
);
	typedef struct packed {
		logic                   valid;
		logic [PMI_PART_W-1:0]  part;
		logic [PMI_GROUP_W-1:0] group;
		logic                   space;
		logic [1:0]             err_sync1;
		logic [1:0]             err_sync2;
		logic [1:0]             of_sync1;
		logic [1:0]             of_sync2;
	} pmi_host_state_t;

	pmi_host_state_t state_reg;
	pmi_host_state_t state_next;

	// Clamp identifiers to the discovered limits before they leave.
	always_comb begin
		state_next = state_reg;
		state_next.valid = req_in;
		if (req_in) begin
			state_next.part  = (part_in > part_max_in) ? part_max_in : part_in;
			state_next.group = (group_in > group_max_in) ? group_max_in : group_in;
			state_next.space = space_in;
		end
		// Interrupts come from another block; synchronise before use.
		state_next.err_sync1 = link.error_irq;
		state_next.err_sync2 = state_reg.err_sync1;
		state_next.of_sync1  = link.overflow_irq;
		state_next.of_sync2  = state_reg.of_sync1;
	end

	// State register.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign link.req_valid           = state_reg.valid;
	assign link.partition_id        = state_reg.part;
	assign link.perf_monitor_group  = state_reg.group;
	assign link.secure_space_select = state_reg.space;
	assign err_irq_out              = state_reg.err_sync2;
	assign of_irq_out               = state_reg.of_sync2;
endmodule : pmi_host

// ---- pmi_link_properties.sv ----
`timescale 1ns/1ps
// Watches the link; the host clamps ids, so their bounds are handed in as parameters.
module pmi_link_properties import pmi_pkg::*; #(
	parameter logic [PMI_PART_W-1:0]  PART_MAX  = 8'h0B,
	parameter logic [PMI_GROUP_W-1:0] GROUP_MAX = 4'h5
) (
	// Clock, reset and link signals.
	input  wire logic                   clk_in,
	input  wire logic                   rst_b_in,
	input  wire logic                   req_valid,
	input  wire logic [PMI_PART_W-1:0]  partition_id,
	input  wire logic [PMI_GROUP_W-1:0] perf_monitor_group,
	input  wire logic                   secure_space_select,
	input  wire logic [1:0]             error_irq,
	input  wire logic [1:0]             overflow_irq
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// Interrupts, request valid and partition id leave reset quiet, so no stale interrupt reaches the controller.
	a_err_s_quiet: assert property ($rose(rst_b_in) |-> !error_irq[0]) else $error("secure error irq after reset");
	a_err_ns_quiet: assert property ($rose(rst_b_in) |-> !error_irq[1]) else $error("error irq after reset");
	a_of_s_quiet: assert property ($rose(rst_b_in) |-> !overflow_irq[0]) else $error("overflow irq after reset");
	a_of_ns_quiet: assert property ($rose(rst_b_in) |-> overflow_irq == 2'h0) else $error("overflow pair set");
	a_req_idle_reset: assert property ($rose(rst_b_in) |-> !req_valid) else $error("request out of reset");
	a_ids_reset: assert property ($rose(rst_b_in) |-> partition_id == 8'h00) else $error("id not cleared");
	// Ids on the link never exceed the bounds the requester is given.
	a_part_range: assert property (req_valid |-> partition_id <= PART_MAX) else $error("partition id too big");
	a_group_range: assert property (req_valid |-> perf_monitor_group <= GROUP_MAX) else $error("group too big");
	c_err_s: cover property ($rose(error_irq[0]));
	c_err_ns: cover property ($rose(error_irq[1]));
	c_of: cover property ($rose(|overflow_irq));
	c_req_ns: cover property (req_valid && secure_space_select);
endmodule // pmi_link_properties

// ---- partition_monitor_irq_logic_test.sv ----
`timescale 1ns/1ps
// Drives the device registers and events and the host requests; results are matched in order.
module partition_monitor_irq_logic_test;
	import pmi_pkg::*;
	localparam logic [7:0] PART_MAX  = 8'h0B;
	localparam logic [3:0] GROUP_MAX = 4'h5;
	logic        clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, rd_d = 1'b0, req_in = 1'b0;
	logic        space_in = 1'b0, req_valid_out, sp;
	logic [3:0]  addr_in = 4'h0, err_code_in = 4'h0, oflow_s_in = 4'h0, oflow_ns_in = 4'h0, group_in = 4'h0;
	logic [31:0] wdata_in = 32'h0, rdata_out, rq[$];
	logic [1:0]  err_det_in = 2'h0, err_irq_out, of_irq_out;
	logic [7:0]  part_in = 8'h00, p;
	logic [15:0] req_setting_out, sq[$], tab[2][16];
	int          miscompares = 0, checked = 0, cycles = 0;
	always #50 clk_in = ~clk_in;
	pmi_link_if pmi_link_if_i ();
	pmi_device pmi_device_i (.clk_in, .rst_b_in, .link(pmi_link_if_i), .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .err_det_in, .err_code_in, .oflow_s_in, .oflow_ns_in, .req_setting_out, .req_valid_out);
	pmi_host pmi_host_i (.clk_in, .rst_b_in, .link(pmi_link_if_i), .req_in, .part_in, .group_in, .space_in,
		.part_max_in(PART_MAX), .group_max_in(GROUP_MAX), .err_irq_out, .of_irq_out);
	pmi_link_properties #(.PART_MAX(PART_MAX), .GROUP_MAX(GROUP_MAX)) pmi_link_properties_i (.clk_in, .rst_b_in,
		.req_valid(pmi_link_if_i.req_valid), .partition_id(pmi_link_if_i.partition_id),
		.perf_monitor_group(pmi_link_if_i.perf_monitor_group),
		.secure_space_select(pmi_link_if_i.secure_space_select),
		.error_irq(pmi_link_if_i.error_irq), .overflow_irq(pmi_link_if_i.overflow_irq));
	task automatic finish_test;
		$display("miscompares %0d checked %0d", miscompares, checked);
		if (miscompares == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One register access; a read notes its expected data for the watcher.
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wr_in <= w;
		rd_in <= !w;
		addr_in <= a;
		wdata_in <= d;
		if (!w) rq.push_back(d);
		@(posedge clk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b0;
	endtask
	// One-cycle hardware event pulse.
	task automatic ev(input logic [1:0] d, input logic [3:0] os, input logic [3:0] ons);
		@(posedge clk_in);
		err_det_in <= d;
		err_code_in <= 4'h9;
		oflow_s_in <= os;
		oflow_ns_in <= ons;
		@(posedge clk_in);
		err_det_in <= 2'h0;
		oflow_s_in <= 4'h0;
		oflow_ns_in <= 4'h0;
	endtask
	// Interrupt levels are checked once the host synchroniser has settled.
	task automatic irq(input logic [31:0] exp);
		repeat (6) @(posedge clk_in);
		cmp({28'h0, of_irq_out, err_irq_out}, exp);
	endtask
	// Watcher takes the oldest note whenever read data or a request setting appears.
	always @(posedge clk_in) begin
		cycles++;
		if (rd_d) cmp(rdata_out, rq.pop_front());
		if (req_valid_out) cmp({16'h0, req_setting_out}, {16'h0, sq.pop_front()});
		rd_d <= rd_in;
		if (cycles > 3000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		void'($urandom(32'hf4178c80));
		repeat (20) @(posedge clk_in);
		rst_b_in <= 1'b1;
		// Each space alone: gate, software raise, clear, hardware detect, then partial overflow clear.
		for (int s = 0; s < 2; s++) begin
			acc(1'b1, 4'(4 * s), 32'h5);
			irq(32'h0);
			acc(1'b1, 4'(4 * s) + PMI_OFS_ECR_S, 32'h1);
			irq(32'(1 << s));
			acc(1'b1, 4'(4 * s), 32'h0);
			irq(32'h0);
			ev(2'(1 << s), 4'h0, 4'h0);
			irq(32'(1 << s));
			acc(1'b0, 4'(4 * s), 32'h9);
			acc(1'b1, 4'(4 * s), 32'h0);
			acc(1'b1, 4'(4 * s) + PMI_OFS_MON_S, 32'h5);
			ev(2'h0, s ? 4'h0 : 4'h7, s ? 4'h7 : 4'h0);
			irq(32'(4 << s));
			acc(1'b0, 4'(4 * s) + PMI_OFS_MON_S, 32'h705);
			acc(1'b1, 4'(4 * s) + PMI_OFS_MON_S, 32'hB05);
			irq(32'(4 << s));
			acc(1'b1, 4'(4 * s) + PMI_OFS_MON_S, 32'h5);
			irq(32'h0);
		end
		acc(1'b0, 4'hF, 32'h0);
		// Fill both tables, then stream back-to-back requests with ids beyond the bounds.
		for (int i = 0; i < 32; i++) begin
			tab[i / 16][i % 16] = 16'($urandom);
			acc(1'b1, PMI_OFS_SET, {4'h0, 4'(i), 7'h00, 1'(i / 16), tab[i / 16][i % 16]});
		end
		for (int i = 0; i < 24; i++) begin
			p = 8'($urandom);
			sp = 1'($urandom);
			@(posedge clk_in);
			part_in <= p;
			group_in <= 4'($urandom);
			space_in <= sp;
			req_in <= 1'b1;
			sq.push_back(tab[sp][4'(p > PART_MAX ? PART_MAX : p)]);
		end
		@(posedge clk_in);
		req_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		// Every noted read and request result must have been seen by the watcher.
		cmp(32'(rq.size() + sq.size()), 32'h0);
		finish_test();
	end
endmodule // partition_monitor_irq_logic_test
